// ===== common/flash_protect_pkg.sv
package flash_protect_pkg;

  // Array geometry: 256MB, 64KB blocks, 4KB sectors
  localparam int ADDR_W    = 28;
  localparam int BLOCK_W   = 12;
  localparam int SECTOR_W  = 4;
  localparam int BLOCK_LSB = 16;
  localparam int SECT_LSB  = 12;
  localparam logic [BLOCK_W-1:0] LAST_BLOCK = 12'hFFF;

  // Host opcodes handled by this block
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_BLOCK_LOCK    = 8'h36;
  localparam logic [7:0] OP_BLOCK_UNLOCK  = 8'h39;
  localparam logic [7:0] OP_READ_LOCK     = 8'h3D;
  localparam logic [7:0] OP_GLOBAL_LOCK   = 8'h7E;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_SUSPEND       = 8'h75;
  localparam logic [7:0] OP_RESUME        = 8'h7A;
  localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
  localparam logic [7:0] OP_RESET         = 8'h99;
  localparam logic [7:0] OP_ADDR4_ENTER   = 8'hB7;
  localparam logic [7:0] OP_ADDR4_EXIT    = 8'hE9;

  // Frame byte counts: opcode plus address or data bytes
  localparam logic [2:0] NBYTES_ADDR3 = 3'h4;
  localparam logic [2:0] NBYTES_ADDR4 = 3'h5;
  localparam logic [2:0] NBYTES_DATA1 = 3'h2;

  // Register offsets on the plain software port
  localparam logic [1:0] REG_STATUS    = 2'h0;
  localparam logic [1:0] REG_FLAG      = 2'h1;
  localparam logic [1:0] REG_CONTROL   = 2'h2;
  localparam logic [1:0] REG_LOCK_READ = 2'h3;

  // Control register fields
  localparam int CTRL_SCHEME_POS = 0;
  localparam int CTRL_PERM_POS   = 1;
  localparam logic CTRL_SCHEME_RESET = 1'b1;
  localparam logic CTRL_PERM_RESET   = 1'b0;

  // Status byte fields
  localparam int ST_LOCK_POS = 7;
  localparam int ST_BP_LSB   = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Array operation kinds asked for by the program/erase engine
  typedef enum logic [1:0] {
    KIND_PROGRAM      = 2'h0,
    KIND_SECTOR_ERASE = 2'h1,
    KIND_BLOCK_ERASE  = 2'h2,
    KIND_CHIP_ERASE   = 2'h3
  } op_kind_t;

  // One complete host frame, bytes after the opcode packed low
  typedef struct packed {
    logic [7:0]  opcode;
    logic [31:0] payload;
    logic [2:0]  nbytes;
  } frame_t;

  // Software reset sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b01,
    SEQ_ARMED = 2'b10
  } reset_seq_t;

endpackage

// ===== rtl/flash_protect_status_logic.sv
`timescale 1ns/1ps
module flash_protect_status_logic #(
  parameter int BLOCKS  = 4096,   // 64KB blocks in the array
  parameter int SECTORS = 16      // 4KB sectors per block
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          sclk,
  input  wire logic                          cs_n,
  input  wire logic                          si,
  input  wire logic                          wp_n,
  input  wire logic [3:0]                    ext_addr,
  input  wire logic                          array_busy,
  input  wire logic                          array_erasing,
  input  wire logic                          cfg_busy,
  input  wire logic                          op_req,
  input  wire flash_protect_pkg::op_kind_t   op_kind,
  input  wire logic [27:0]                   op_addr,
  input  wire logic                          op_done,
  input  wire logic                          program_fail,
  input  wire logic                          erase_fail,
  input  wire logic                          otp_program_hit,
  input  wire logic                          otp_erase_hit,
  input  wire logic [1:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [7:0]                         reg_rdata,
  output logic                               op_allow,
  output logic                               op_deny,
  output logic                               suspend_req,
  output logic                               resume_req,
  output logic                               lock_state,
  output logic [7:0]                         status_byte,
  output logic [7:0]                         flag_byte
);

  flash_protect_pkg::frame_t     frame;        // Last host frame
  logic                          frame_valid;  // One-cycle frame strobe
  flash_protect_pkg::reset_seq_t seq_state;    // Soft reset sequencer
  logic                          soft_reset;   // 66H then 99H seen
  logic                          wp_meta;      // Pin sync stage one
  logic                          wp_sync;      // Pin sync stage two
  logic [BLOCKS-1:0]             block_lock;   // One bit per middle block
  logic [SECTORS-1:0]            first_lock;   // Sectors of block 0
  logic [SECTORS-1:0]            last_lock;    // Sectors of last block
  logic                          status_lock;       // status_lock_bit
  logic [4:0]                    protect_range;     // Protect field
  logic                          write_enable_latch;
  logic                          protect_scheme_select;
  logic                          status_permanent_lock_bit;
  logic                          address_width_flag;
  logic                          protection_error_flag;
  logic                          program_error_flag;
  logic                          erase_error_flag;
  logic                          erase_suspended_flag;
  logic                          program_suspended_flag;
  logic                          operation_busy_flag;
  logic                          ready_busy_flag;
  logic [27:0]                   cmd_addr;     // Full address of a frame
  logic                          cmd_addr_ok;  // Frame carried an address
  logic                          status_write_ok;
  logic                          hit;          // Requested op protected
  logic                          any_protected;
  logic                          is_program;

  // Host command frames
  spi_frame_receiver u_rx (
    .clk         (clk),
    .rst         (rst),
    .sclk        (sclk),
    .cs_n        (cs_n),
    .si          (si),
    .frame       (frame),
    .frame_valid (frame_valid)
  );

  // Range decode: lower or upper region by top bit, or whole array
  function automatic logic range_hit(input logic [4:0] bp, input logic [11:0] blk);
    logic [12:0] span;
    span = 13'h0;
    if (bp[3:0] == 4'hD || bp[3:1] == 3'h7) begin
      range_hit = 1'b1;
    end else if (bp[3:0] == 4'h0) begin
      range_hit = 1'b0;
    end else begin
      // Region size in blocks is 2^(code-1), 1 up to 2048
      span = 13'h1 << (bp[3:0] - 4'h1);
      if (bp[4]) begin
        range_hit = {1'b0, blk} < span;
      end else begin
        range_hit = {1'b0, blk} >= (13'h1000 - span);
      end
    end
  endfunction

  // Individual lock lookup, sector granular at both ends of the array
  function automatic logic lock_hit(input logic [27:0] a, input logic [BLOCKS-1:0] bl,
                                    input logic [SECTORS-1:0] fl, input logic [SECTORS-1:0] ll);
    logic [11:0] blk;
    logic [3:0]  sec;
    blk = a[flash_protect_pkg::BLOCK_LSB +: flash_protect_pkg::BLOCK_W];
    sec = a[flash_protect_pkg::SECT_LSB +: flash_protect_pkg::SECTOR_W];
    if (blk == 12'h0) begin
      lock_hit = fl[sec];
    end else if (blk == flash_protect_pkg::LAST_BLOCK) begin
      lock_hit = ll[sec];
    end else begin
      lock_hit = bl[blk];
    end
  endfunction

  // Write-protect pin synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else begin
      wp_meta <= wp_n;
      wp_sync <= wp_meta;
    end
  end

  // Address of a lock command: 4-byte mode takes it whole,
  // 3-byte mode takes the top nibble from the extended register
  always_comb begin
    if (address_width_flag) begin
      cmd_addr    = frame.payload[27:0];
      cmd_addr_ok = frame.nbytes == flash_protect_pkg::NBYTES_ADDR4;
    end else begin
      cmd_addr    = {ext_addr, frame.payload[23:0]};
      cmd_addr_ok = frame.nbytes == flash_protect_pkg::NBYTES_ADDR3;
    end
  end

  // Soft reset needs 66H immediately followed by 99H
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_state <= flash_protect_pkg::SEQ_IDLE;
    end else if (frame_valid) begin
      case (seq_state)
        flash_protect_pkg::SEQ_IDLE: begin
          if (frame.opcode == flash_protect_pkg::OP_RESET_ENABLE) begin
            seq_state <= flash_protect_pkg::SEQ_ARMED;
          end
        end
        flash_protect_pkg::SEQ_ARMED: begin
          // Any other opcode disarms the sequence
          seq_state <= flash_protect_pkg::SEQ_IDLE;
        end
        default: begin
          seq_state <= flash_protect_pkg::SEQ_IDLE;
        end
      endcase
    end
  end
  assign soft_reset = frame_valid && seq_state == flash_protect_pkg::SEQ_ARMED &&
                      frame.opcode == flash_protect_pkg::OP_RESET;

  // Volatile lock bits; three vectors, all set or cleared together by global ops
  always_ff @(posedge clk) begin
    if (rst || soft_reset) begin
      block_lock <= '0;
      first_lock <= '0;
      last_lock  <= '0;
    end else if (frame_valid) begin
      case (frame.opcode)
        flash_protect_pkg::OP_GLOBAL_LOCK: begin
          block_lock <= '1;
          first_lock <= '1;
          last_lock  <= '1;
        end
        flash_protect_pkg::OP_GLOBAL_UNLOCK: begin
          block_lock <= '0;
          first_lock <= '0;
          last_lock  <= '0;
        end
        flash_protect_pkg::OP_BLOCK_LOCK, flash_protect_pkg::OP_BLOCK_UNLOCK: begin
          // Frames without a full address are ignored
          if (cmd_addr_ok) begin
            if (cmd_addr[27:16] == 12'h0) begin
              first_lock[cmd_addr[15:12]] <= frame.opcode == flash_protect_pkg::OP_BLOCK_LOCK;
            end else if (cmd_addr[27:16] == flash_protect_pkg::LAST_BLOCK) begin
              last_lock[cmd_addr[15:12]] <= frame.opcode == flash_protect_pkg::OP_BLOCK_LOCK;
            end else begin
              block_lock[cmd_addr[27:16]] <= frame.opcode == flash_protect_pkg::OP_BLOCK_LOCK;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Lock readback answer for 3DH
  always_ff @(posedge clk) begin
    if (rst || soft_reset) begin
      lock_state <= 1'b0;
    end else if (frame_valid && frame.opcode == flash_protect_pkg::OP_READ_LOCK && cmd_addr_ok) begin
      lock_state <= lock_hit(cmd_addr, block_lock, first_lock, last_lock);
    end
  end

  // Status write gate from the lock bits and the pin
  always_comb begin
    if (!status_lock) begin
      status_write_ok = write_enable_latch;
    end else if (status_permanent_lock_bit) begin
      status_write_ok = 1'b0;
    end else if (!wp_sync) begin
      status_write_ok = 1'b0;
    end else begin
      status_write_ok = write_enable_latch;
    end
  end

  // Nonvolatile status fields; only a device power-up restores them
  always_ff @(posedge clk) begin
    if (rst) begin
      status_lock   <= flash_protect_pkg::STATUS_RESET[flash_protect_pkg::ST_LOCK_POS];
      protect_range <= flash_protect_pkg::STATUS_RESET[flash_protect_pkg::ST_BP_LSB +: 5];
    end else if (frame_valid && frame.opcode == flash_protect_pkg::OP_STATUS_WRITE &&
                 frame.nbytes == flash_protect_pkg::NBYTES_DATA1 && status_write_ok) begin
      status_lock   <= frame.payload[flash_protect_pkg::ST_LOCK_POS];
      protect_range <= frame.payload[flash_protect_pkg::ST_BP_LSB +: 5];
    end
  end

  // Write enable latch; set wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst || soft_reset) begin
      write_enable_latch <= 1'b0;
    end else if (frame_valid && frame.opcode == flash_protect_pkg::OP_WRITE_ENABLE) begin
      write_enable_latch <= 1'b1;
    end else if (op_done) begin
      write_enable_latch <= 1'b0;
    end else if (frame_valid && (frame.opcode == flash_protect_pkg::OP_WRITE_DISABLE ||
                 (frame.opcode == flash_protect_pkg::OP_STATUS_WRITE && status_write_ok))) begin
      write_enable_latch <= 1'b0;
    end
  end

  // Address mode follows 4-byte enter and exit commands
  always_ff @(posedge clk) begin
    if (rst || soft_reset) begin
      address_width_flag <= 1'b0;
    end else if (frame_valid && frame.opcode == flash_protect_pkg::OP_ADDR4_ENTER) begin
      address_width_flag <= 1'b1;
    end else if (frame_valid && frame.opcode == flash_protect_pkg::OP_ADDR4_EXIT) begin
      address_width_flag <= 1'b0;
    end
  end

  // Software control: scheme select and permanent lock
  always_ff @(posedge clk) begin
    if (rst) begin
      protect_scheme_select     <= flash_protect_pkg::CTRL_SCHEME_RESET;
      status_permanent_lock_bit <= flash_protect_pkg::CTRL_PERM_RESET;
    end else if (reg_wr && reg_addr == flash_protect_pkg::REG_CONTROL) begin
      protect_scheme_select <= reg_wdata[flash_protect_pkg::CTRL_SCHEME_POS];
      // Permanent lock is one-way: software can only set it
      status_permanent_lock_bit <= status_permanent_lock_bit | reg_wdata[flash_protect_pkg::CTRL_PERM_POS];
    end
  end

  // Protection check over the full array address
  assign is_program = op_kind == flash_protect_pkg::KIND_PROGRAM;
  always_comb begin
    if (protect_scheme_select) begin
      any_protected = protect_range[3:0] != 4'h0;
      hit = range_hit(protect_range, op_addr[27:16]);
    end else begin
      // Block 0 and the last block use their sector bits instead
      any_protected = (|block_lock[BLOCKS-2:1]) | (|first_lock) | (|last_lock);
      hit = lock_hit(op_addr, block_lock, first_lock, last_lock);
    end
    if (op_kind == flash_protect_pkg::KIND_CHIP_ERASE) begin
      hit = any_protected;
    end
  end

  // Grant or refusal, one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      op_allow <= 1'b0;
      op_deny  <= 1'b0;
    end else begin
      op_allow <= op_req && write_enable_latch && !hit;
      op_deny  <= op_req && (!write_enable_latch || hit);
    end
  end

  // Suspend and resume pulses to the array engine
  always_ff @(posedge clk) begin
    if (rst) begin
      suspend_req <= 1'b0;
      resume_req  <= 1'b0;
    end else begin
      suspend_req <= frame_valid && frame.opcode == flash_protect_pkg::OP_SUSPEND && array_busy;
      resume_req  <= frame_valid && frame.opcode == flash_protect_pkg::OP_RESUME;
    end
  end

  // Suspend flags; suspend only counts while the engine is busy
  always_ff @(posedge clk) begin
    if (rst || soft_reset) begin
      erase_suspended_flag   <= 1'b0;
      program_suspended_flag <= 1'b0;
    end else if (frame_valid && frame.opcode == flash_protect_pkg::OP_SUSPEND && array_busy) begin
      erase_suspended_flag   <= erase_suspended_flag | array_erasing;
      program_suspended_flag <= program_suspended_flag | !array_erasing;
    end else if (frame_valid && frame.opcode == flash_protect_pkg::OP_RESUME) begin
      erase_suspended_flag   <= 1'b0;
      program_suspended_flag <= 1'b0;
    end
  end

  // Error flags: a fresh event outranks the resume that clears it
  always_ff @(posedge clk) begin
    if (rst || soft_reset) begin
      protection_error_flag <= 1'b0;
      program_error_flag    <= 1'b0;
      erase_error_flag      <= 1'b0;
    end else begin
      protection_error_flag <= (protection_error_flag && !resume_req) ||
                               (op_req && write_enable_latch && hit) || otp_program_hit;
      program_error_flag <= (program_error_flag && !(resume_req && !erase_suspended_flag)) ||
                            program_fail || otp_program_hit ||
                            (op_req && write_enable_latch && hit && is_program);
      erase_error_flag <= (erase_error_flag && !(resume_req && erase_suspended_flag)) ||
                          erase_fail || otp_erase_hit ||
                          (op_req && write_enable_latch && hit && !is_program);
    end
  end

  // Busy covers array cycles and register write cycles
  assign operation_busy_flag = array_busy || cfg_busy;
  assign ready_busy_flag     = !operation_busy_flag;

  // Register images driven to the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      status_byte <= '0;
      flag_byte   <= '0;
    end else begin
      status_byte <= {status_lock, protect_range, write_enable_latch, operation_busy_flag};
      flag_byte   <= {ready_busy_flag, erase_suspended_flag, erase_error_flag, program_error_flag,
                      1'b0, program_suspended_flag, protection_error_flag, address_width_flag};
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        flash_protect_pkg::REG_STATUS:    reg_rdata <= status_byte;
        flash_protect_pkg::REG_FLAG:      reg_rdata <= flag_byte;
        flash_protect_pkg::REG_CONTROL:   reg_rdata <= {6'h00, status_permanent_lock_bit, protect_scheme_select};
        flash_protect_pkg::REG_LOCK_READ: reg_rdata <= {7'h00, lock_state};
        default:                          reg_rdata <= '0;
      endcase
    end else begin
      // Data stand only in the cycle after the strobe
      reg_rdata <= '0;
    end
  end

endmodule

// ===== rtl/spi_frame_receiver.sv
`timescale 1ns/1ps
module spi_frame_receiver (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     sclk,
  input  wire logic                     cs_n,
  input  wire logic                     si,
  output flash_protect_pkg::frame_t     frame,
  output logic                          frame_valid
);

  // Two-flop synchronisers; stage one feeds only stage two
  logic [2:0] sclk_meta, sclk_sync;
  logic       cs_meta, cs_sync, cs_prev;
  logic       si_meta, si_sync;
  logic       sclk_prev;
  logic [2:0] bit_cnt;     // Bits within the current byte
  logic [7:0] shift;       // Byte being assembled
  logic [2:0] byte_cnt;    // Whole bytes seen, saturating
  logic [7:0] opcode;      // First byte of the frame
  logic [31:0] payload;    // Last four bytes after the opcode

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_meta <= '0;
      cs_meta   <= 1'b1;
      cs_sync   <= 1'b1;
      si_meta   <= 1'b0;
      si_sync   <= 1'b0;
    end else begin
      sclk_meta <= {sclk_meta[1:0], sclk};
      cs_meta   <= cs_n;
      cs_sync   <= cs_meta;
      si_meta   <= si;
      si_sync   <= si_meta;
    end
  end
  assign sclk_sync = sclk_meta;

  // Edge history on the synchronised copies only
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_prev <= 1'b0;
      cs_prev   <= 1'b1;
    end else begin
      sclk_prev <= sclk_sync[1];
      cs_prev   <= cs_sync;
    end
  end

  // Data latched on rising serial clock, modes 0 and 3 alike
  always_ff @(posedge clk) begin
    if (rst || cs_sync) begin
      bit_cnt  <= '0;
      byte_cnt <= '0;
      shift    <= '0;
      opcode   <= '0;
      payload  <= '0;
    end else if (sclk_sync[1] && !sclk_prev) begin
      shift   <= {shift[6:0], si_sync};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        // Count saturates so long data bursts cannot wrap it
        if (byte_cnt != 3'h7) begin
          byte_cnt <= byte_cnt + 3'h1;
        end
        if (byte_cnt == 3'h0) begin
          opcode <= {shift[6:0], si_sync};
        end else begin
          payload <= {payload[23:0], shift[6:0], si_sync};
        end
      end
    end
  end

  // Frame handed over when chip select rises
  always_ff @(posedge clk) begin
    if (rst) begin
      frame       <= '0;
      frame_valid <= 1'b0;
    end else begin
      frame_valid <= cs_sync && !cs_prev && (byte_cnt != 3'h0);
      if (cs_sync && !cs_prev) begin
        frame.opcode  <= opcode;
        frame.payload <= payload;
        frame.nbytes  <= byte_cnt;
      end
    end
  end

endmodule

// ===== testbench/flash_protect_props.sv
`timescale 1ns/1ps
module flash_protect_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       array_busy,
  input wire logic       cfg_busy,
  input wire logic       op_req,
  input wire logic [1:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       op_allow,
  input wire logic       op_deny,
  input wire logic       suspend_req,
  input wire logic       resume_req,
  input wire logic       lock_state,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] flag_byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Latch seen clear on both cycles, so the decision saw it clear too
  deny_unlatched_a: assert property (op_req && !status_byte[1] ##1 !status_byte[1] |-> op_deny)
    else $error("op granted with write latch clear");
  answer_paired_a: assert property (op_allow || op_deny |-> $past(op_req) && !(op_allow && op_deny))
    else $error("op answer without request");
  flag_reserved_a: assert property (flag_byte[3] == 1'b0)
    else $error("reserved flag bit set");
  busy_shown_a: assert property ((array_busy || cfg_busy) [*3] |-> status_byte[0] && !flag_byte[7])
    else $error("busy not shown");
  read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  read_flag_a: assert property (reg_rd && reg_addr == 2'h1 ##1 $stable(flag_byte) |-> reg_rdata == flag_byte)
    else $error("flag read mismatch");
  reset_clear_a: assert property ($past(rst) |-> status_byte[1:0] == 2'h0 && flag_byte[6:0] == 7'h00 && !lock_state)
    else $error("volatile state survived reset");
  suspend_pulse_a: assert property (suspend_req |=> !suspend_req)
    else $error("suspend request longer than a pulse");
  resume_pulse_a: assert property (resume_req |=> !resume_req)
    else $error("resume request longer than a pulse");
  cover property (op_deny);
  cover property (suspend_req);
  cover property (lock_state);
endmodule
bind flash_protect_status_logic flash_protect_props u_props (.*);

// ===== testbench/spi_host_model.sv
`timescale 1ns/1ps
// Host end of the serial link, clock idle low between frames
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic si
);
  initial begin
    sclk = 0;
    cs_n = 1;
    si = 0;
  end
  // Opcode then address bytes, MSB first
  task automatic send(input logic [39:0] d, input int n);
    cs_n = 0;
    for (int i = 8 * n - 1; i >= 0; i--) begin
      si = d[i];
      #40 sclk = 1;
      #40 sclk = 0;
    end
    #40 cs_n = 1;
    si = ~si; // No stale bit once released
    #100;
  endtask
endmodule

// ===== testbench/tb_flash_protect_status_logic.sv
`timescale 1ns/1ps
module tb_flash_protect_status_logic;
  logic clk = 0, rst = 1, wp_n = 1, array_busy = 0, array_erasing = 0, cfg_busy = 0, op_req = 0, op_done = 0;
  logic program_fail = 0, erase_fail = 0, otp_program_hit = 0, otp_erase_hit = 0, reg_wr = 0, reg_rd = 0;
  logic op_allow, op_deny, suspend_req, resume_req, lock_state, sclk, cs_n, si;
  logic [1:0]  reg_addr = 0;
  logic [3:0]  ext_addr = 0;
  logic [7:0]  reg_wdata = 0, reg_rdata, status_byte, flag_byte;
  logic [27:0] op_addr = 0;
  flash_protect_pkg::op_kind_t op_kind = flash_protect_pkg::KIND_PROGRAM;
  int bad_count = 0, checks_done = 0;
  flash_protect_status_logic u_dut (.*);
  spi_host_model u_host (.*);
  always #5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  // Engine request; answer is checked in its single-cycle slot
  task automatic op(input logic [1:0] k, input logic [27:0] a, input logic ok);
    @(posedge clk);
    op_req <= 1;
    op_kind <= flash_protect_pkg::op_kind_t'(k);
    op_addr <= a;
    @(posedge clk);
    op_req <= 0;
    #1 chk(op_allow, ok);
    chk(op_deny, !ok);
  endtask
  task automatic sw(input logic [7:0] d); // Write enable then status write
    u_host.send(40'h06, 1);
    u_host.send({8'h01, d}, 2);
  endtask
  task automatic t_reset;
    rd(0, 8'h00);
    rd(1, 8'h80);
    wr(1, 8'hFF);
    rd(1, 8'h80);
    rd(2, 8'h01);
    $display("reset test done");
  endtask
  task automatic t_range;
    op(0, 0, 0);
    sw(8'h70);
    chk(status_byte & 8'hFC, 8'h70);
    u_host.send(40'h06, 1);
    chk(status_byte, 8'h72);
    op(0, 28'h7FFFFFF, 0);
    repeat (2) @(posedge clk);
    chk(flag_byte & 8'h12, 8'h12);
    op(0, 28'h8000000, 1);
    op(3, 0, 0);
    @(posedge clk) op_done <= 1;
    @(posedge clk) op_done <= 0;
    repeat (3) @(posedge clk);
    chk(status_byte[1], 0);
    sw(8'h34);
    u_host.send(40'h06, 1);
    op(0, 28'hFFFFFFF, 0);
    $display("range test done");
  endtask
  task automatic t_locks;
    wr(2, 8'h00);
    op(0, 28'hFFFFFFF, 1);
    u_host.send({8'h36, 24'h120000}, 4);
    u_host.send({8'h3D, 24'h120000}, 4);
    chk(lock_state, 1);
    op(1, 28'h120000, 0);
    u_host.send({8'h39, 24'h120000}, 4);
    u_host.send({8'h3D, 24'h120000}, 4);
    chk(lock_state, 0);
    u_host.send(40'h7E, 1);
    u_host.send({8'h3D, 24'h345678}, 4);
    chk(lock_state, 1);
    u_host.send(40'h98, 1);
    u_host.send({8'h3D, 24'h345678}, 4);
    chk(lock_state, 0);
    u_host.send({8'h36, 24'h001000}, 4);
    u_host.send({8'h3D, 24'h002000}, 4);
    chk(lock_state, 0);
    u_host.send(40'hB7, 1);
    chk(flag_byte[0], 1);
    u_host.send({8'h36, 32'h0FFF1000}, 5);
    u_host.send({8'h3D, 32'h0FFF1000}, 5);
    chk(lock_state, 1);
    u_host.send(40'hE9, 1);
    chk(flag_byte[0], 0);
    $display("lock test done");
  endtask
  task automatic t_susp;
    @(posedge clk);
    array_busy <= 1;
    array_erasing <= 1;
    u_host.send(40'h75, 1);
    chk(flag_byte[6], 1);
    u_host.send(40'h7A, 1);
    chk(flag_byte[6], 0);
    @(posedge clk);
    array_erasing <= 0;
    u_host.send(40'h75, 1);
    chk(flag_byte[2], 1);
    u_host.send(40'h66, 1);
    u_host.send(40'h99, 1);
    chk(flag_byte & 8'h77, 0);
    @(posedge clk);
    array_busy <= 0;
    u_host.send({8'h3D, 24'h001000}, 4);
    chk(lock_state, 0);
    $display("suspend test done");
  endtask
  task automatic t_wp;
    sw(8'h80);
    wp_n <= 0;
    sw(8'h84);
    chk(status_byte & 8'hFC, 8'h80);
    wp_n <= 1;
    sw(8'h84);
    chk(status_byte & 8'hFC, 8'h84);
    wr(2, 8'h02);
    sw(8'h80);
    chk(status_byte & 8'hFC, 8'h84);
    $display("protect pin test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    t_reset();
    t_range();
    t_locks();
    t_susp();
    t_wp();
    stop_test();
  end
  initial begin // Hang guard
    #1ms bad_count++;
    stop_test();
  end
endmodule
